// File: logic/lcd_char_format_regs.vh
// Register offsets, field positions, reset values and limits
`ifndef LCD_CHAR_FORMAT_REGS_VH
`define LCD_CHAR_FORMAT_REGS_VH

// Register indices; byte address is index times four
`define IDX_MEM_CFG        3'h0
`define IDX_AC_HSIZE       3'h1
`define IDX_VCELL          3'h2
`define IDX_DISP_BYTES     3'h3
`define IDX_TOTAL_BYTES    3'h4
`define IDX_STATUS         3'h5
`define IDX_FRAME_LINES    3'h6
`define IDX_LAST           3'h6

// Memory configuration fields
`define MC_GEN_SEL         0
`define MC_RSVD1           1
`define MC_HEIGHT_SEL      2
`define MC_DUAL_PANEL      3
`define MC_RSVD4           4
`define MC_ORIGIN_OFF      5
`define MC_RESET           8'h10
`define MC_WMASK           8'h2d

// AC drive and horizontal size fields
`define AC_MODE_BIT        7
`define AC_WMASK           8'h8f
`define AC_RESET           8'h00

`define VCELL_WMASK        8'h0f
`define VCELL_RESET        8'h00
`define DISP_RESET         8'h00
`define TOTAL_RESET        8'h00
`define LINE_FIELD_OFS     8'h02
`define FRAME_RESET        8'hff

// Character generator limits
`define FIXED_COUNT        9'h0a0
`define FIXED_WIDTH        4'h5
`define FIXED_HEIGHT       5'h07
`define USER_COUNT         9'h100
`define USER_COUNT_SHARED  9'h040
`define USER_SHARED_ROWS   5'h08
`define ROWS_SHORT         5'h08
`define ROWS_TALL          5'h10
`define AC_LINES           4'hf

`define HTRANS_NONSEQ      2'h2
`endif

// File: logic/lcd_char_format.v
// Character format registers and line timing for a character LCD engine
// Function
// - Height select 0 gives 8, 1 gives 16
// - Generator select picks fixed or user patterns
// - Fixed generator: 160 unalterable 5x7 characters
// - User memory: 256 characters at start address
// - With fixed generator, user memory 64 8x8
// - User pattern memory forces one bit per pixel
// - AC select 0 is 16-line; else two-frame
// - 16-line mode toggles alternation every 16 lines from frame start; frame end clears it
// - Vertical cell field is height minus one
// - Total bytes field is line length plus one
// - Total field sets whole line, up to 254 slots
// - Origin compensation shifts patterns one row down
// - Reserved memory config bit 1 resets to 0
`timescale 1ns/1ps
`include "lcd_char_format_regs.vh"
`default_nettype none

module lcd_char_format
(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire [7:0]  char_code,
   input  wire [15:0] cg_start_addr,
   output reg         line_start,
   output reg         frame_start,
   output reg         display_active,
   output reg         panel_alt,
   output reg  [7:0]  line_byte,
   output reg  [7:0]  frame_line,
   output reg  [3:0]  cell_row,
   output reg  [4:0]  pattern_row,
   output reg         pattern_row_visible,
   output reg         use_user_patterns,
   output reg         one_bpp_only,
   output reg  [4:0]  char_rows,
   output reg  [3:0]  cell_width_m1,
   output reg  [8:0]  pattern_count,
   output reg  [3:0]  fixed_width,
   output reg  [4:0]  fixed_height,
   output reg         code_valid,
   output reg  [15:0] user_pattern_addr
);

   reg  [7:0] mem_cfg_q;
   reg  [7:0] ac_hsize_q;
   reg  [7:0] vcell_q;
   reg  [7:0] disp_bytes_q;
   reg  [7:0] total_bytes_q;
   reg  [7:0] frame_lines_q;
   reg        wr_pend_q;
   reg        rd_pend_q;
   reg        rd_wait_q;
   reg  [2:0] addr_idx_q;
   reg        addr_ok_q;
   reg        restart_q;
   reg  [3:0] ac_cnt_q;
   wire       take;
   wire       mapped;
   wire [2:0] idx;
   wire       line_end;
   wire       frame_end;
   wire [7:0] line_last;
   reg  [7:0] rd_val;
   reg  [4:0] shifted_row;
   reg  [15:0] code_off;

   // Register index decode, used for both read and write
   function [2:0] reg_index;
      input [31:0] a;
      begin
         reg_index = a[4:2];
      end
   endfunction

   function in_map;
      input [31:0] a;
      begin
         in_map = (a[31:5] == 27'h0) && (a[1:0] == 2'h0)
                  && (a[4:2] <= `IDX_LAST);
      end
   endfunction

   assign take = hsel & hready & (htrans == `HTRANS_NONSEQ);
   assign idx = reg_index(haddr);
   assign mapped = in_map(haddr);
   // One wait state on reads so a read right after a write sees it
   assign hreadyout = ~rd_wait_q;
   assign hresp = 1'b0;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rd_wait_q <= 1'b0;
         addr_idx_q <= 3'h0;
         addr_ok_q <= 1'b0;
      end
      else
      begin
         if (hready)
         begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            rd_wait_q <= take & ~hwrite;
            addr_idx_q <= idx;
            addr_ok_q <= mapped;
         end
         else
         begin
            wr_pend_q <= 1'b0;
            rd_wait_q <= 1'b0;
         end
      end
   end

   always @*
   begin
      case (addr_idx_q)
         `IDX_MEM_CFG:     rd_val = mem_cfg_q;
         `IDX_AC_HSIZE:    rd_val = ac_hsize_q;
         `IDX_VCELL:       rd_val = vcell_q;
         `IDX_DISP_BYTES:  rd_val = disp_bytes_q;
         `IDX_TOTAL_BYTES: rd_val = total_bytes_q;
         `IDX_STATUS:      rd_val = {panel_alt, display_active, 2'h0,
                                     cell_row};
         `IDX_FRAME_LINES: rd_val = frame_lines_q;
         default:          rd_val = 8'h00;
      endcase
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (rd_pend_q && rd_wait_q)
         hrdata <= addr_ok_q ? {24'h0, rd_val} : 32'h0;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mem_cfg_q <= `MC_RESET;
         ac_hsize_q <= `AC_RESET;
         vcell_q <= `VCELL_RESET;
         disp_bytes_q <= `DISP_RESET;
         total_bytes_q <= `TOTAL_RESET;
         frame_lines_q <= `FRAME_RESET;
         restart_q <= 1'b1;
      end
      else
      begin
         restart_q <= 1'b0;
         if (wr_pend_q && addr_ok_q)
         begin
            case (addr_idx_q)
               `IDX_MEM_CFG:
               begin
                  // Reserved bit 1 stays 0, bit 4 stays 1
                  mem_cfg_q <= (hwdata[7:0] & `MC_WMASK)
                               | `MC_RESET;
                  // Config write restarts the timing generator
                  restart_q <= 1'b1;
               end
               `IDX_AC_HSIZE:    ac_hsize_q <= hwdata[7:0] & `AC_WMASK;
               `IDX_VCELL:       vcell_q <= hwdata[7:0] & `VCELL_WMASK;
               `IDX_DISP_BYTES:  disp_bytes_q <= hwdata[7:0];
               `IDX_TOTAL_BYTES: total_bytes_q <= hwdata[7:0];
               `IDX_FRAME_LINES: frame_lines_q <= hwdata[7:0];
               default:          ;
            endcase
         end
      end
   end

   // Field holds line length plus one, so last slot is field minus two;
   // fields below two are not legal and give one-slot lines
   assign line_last = (total_bytes_q < `LINE_FIELD_OFS) ? 8'h00
                      : total_bytes_q - `LINE_FIELD_OFS;
   assign line_end = (line_byte == line_last);
   assign frame_end = line_end && (frame_line == frame_lines_q);

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         line_byte <= 8'h00;
         frame_line <= 8'h00;
         cell_row <= 4'h0;
         ac_cnt_q <= 4'h0;
         panel_alt <= 1'b0;
         line_start <= 1'b0;
         frame_start <= 1'b0;
         display_active <= 1'b0;
      end
      else if (restart_q)
      begin
         line_byte <= 8'h00;
         frame_line <= 8'h00;
         cell_row <= 4'h0;
         ac_cnt_q <= 4'h0;
         panel_alt <= 1'b0;
         line_start <= 1'b1;
         frame_start <= 1'b1;
         display_active <= 1'b1;
      end
      else
      begin
         line_start <= line_end;
         frame_start <= frame_end;
         line_byte <= line_end ? 8'h00 : line_byte + 8'h01;
         // Display field counts bytes minus one, so slot equal is last
         display_active <= line_end ? 1'b1
                           : (line_byte < disp_bytes_q);
         if (frame_end)
         begin
            frame_line <= 8'h00;
            cell_row <= 4'h0;
            ac_cnt_q <= 4'h0;
            if (ac_hsize_q[`AC_MODE_BIT])
               panel_alt <= ~panel_alt;
            else
               panel_alt <= 1'b0;
         end
         else if (line_end)
         begin
            frame_line <= frame_line + 8'h01;
            cell_row <= (cell_row == vcell_q[3:0]) ? 4'h0
                        : cell_row + 4'h1;
            ac_cnt_q <= ac_cnt_q + 4'h1;
            if (!ac_hsize_q[`AC_MODE_BIT] && ac_cnt_q == `AC_LINES)
               panel_alt <= ~panel_alt;
         end
      end
   end

   always @*
   begin
      char_rows = mem_cfg_q[`MC_HEIGHT_SEL] ? `ROWS_TALL
                  : `ROWS_SHORT;
      // Compensation active when bit is clear: pattern drawn a row lower
      if (!mem_cfg_q[`MC_ORIGIN_OFF])
         shifted_row = {1'b0, cell_row} - 5'h01;
      else
         shifted_row = {1'b0, cell_row};
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pattern_row <= 5'h00;
         pattern_row_visible <= 1'b0;
         use_user_patterns <= 1'b0;
         one_bpp_only <= 1'b0;
         cell_width_m1 <= 4'h0;
         pattern_count <= 9'h000;
         fixed_width <= 4'h0;
         fixed_height <= 5'h00;
         code_valid <= 1'b0;
         user_pattern_addr <= 16'h0000;
      end
      else
      begin
         pattern_row <= shifted_row;
         // Row zero under compensation and rows past the bitmap are blank
         pattern_row_visible <= (shifted_row < char_rows)
                                && !(shifted_row[4]);
         use_user_patterns <= mem_cfg_q[`MC_GEN_SEL];
         one_bpp_only <= mem_cfg_q[`MC_GEN_SEL];
         cell_width_m1 <= ac_hsize_q[3:0];
         fixed_width <= `FIXED_WIDTH;
         fixed_height <= `FIXED_HEIGHT;
         if (mem_cfg_q[`MC_GEN_SEL])
         begin
            pattern_count <= `USER_COUNT;
            code_valid <= 1'b1;
            user_pattern_addr <= cg_start_addr + code_off
                                 + {11'h0, shifted_row};
         end
         else
         begin
            // Shared user area is limited to 64 short characters
            pattern_count <= `FIXED_COUNT;
            code_valid <= ({1'b0, char_code} < `FIXED_COUNT);
            user_pattern_addr <= cg_start_addr
                                 + {7'h0, char_code[5:0], 3'h0}
                                 + {11'h0, shifted_row};
         end
      end
   end

   always @*
   begin
      if (mem_cfg_q[`MC_HEIGHT_SEL])
         code_off = {4'h0, char_code, 4'h0};
      else
         code_off = {5'h00, char_code, 3'h0};
   end

endmodule
`default_nettype wire

// File: test/lcd_panel_model.sv
// Panel model that measures alternation spacing in scan lines
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model
(
   input  wire logic       hclk,
   input  wire logic       panel_alt,
   input  wire logic [7:0] line_byte,
   input  wire logic [7:0] frame_line,
   output var  logic [7:0] gap
);
   logic [7:0] cnt_q;
   logic       alt_q;
   // Mid-line sample, so the exact toggle slot does not matter
   always @(posedge hclk)
   begin
      if (line_byte == 8'h02)
      begin
         alt_q <= panel_alt;
         if (panel_alt != alt_q)
         begin
            gap   <= cnt_q;
            cnt_q <= 8'h01;
         end
         else if (frame_line == 8'h00)
            cnt_q <= 8'h01;
         else
            cnt_q <= cnt_q + 8'h01;
      end
   end
endmodule
`default_nettype wire

// File: test/lcd_char_format_assertions.sv
// Port assertions for the character format block
`timescale 1ns/1ps
`default_nettype none
module lcd_char_format_assertions
(
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic [7:0] char_code,
   input wire logic       line_start,
   input wire logic       frame_start,
   input wire logic [7:0] line_byte,
   input wire logic [7:0] frame_line,
   input wire logic [4:0] pattern_row,
   input wire logic       pattern_row_visible,
   input wire logic       use_user_patterns,
   input wire logic       one_bpp_only,
   input wire logic [4:0] char_rows,
   input wire logic [8:0] pattern_count,
   input wire logic       code_valid
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_line_origin: assert property (line_start
      |-> line_byte == 8'h00) else $error("line start off slot zero");
   a_byte_ramp: assert property ($past(hresetn) && !line_start
      |-> line_byte == $past(line_byte) + 8'h01) else $error("slot skipped");
   a_frame_origin: assert property (frame_start
      |-> line_start && frame_line == 8'h00) else $error("frame start late");
   // Flag is registered, so it follows the height of the cycle before
   a_row_visible: assert property (pattern_row_visible
      |-> pattern_row < $past(char_rows)) else $error("row past glyph height");
   a_row_wrap: assert property (pattern_row == 5'h1f
      |-> !pattern_row_visible) else $error("wrapped row shown");
   a_user_bpp: assert property (use_user_patterns == one_bpp_only)
      else $error("depth not forced");
   a_pat_count: assert property ($past(hresetn)
      |-> pattern_count == (use_user_patterns ? 9'h100 : 9'h0a0))
      else $error("bad count");
   a_code_range: assert property ($past(hresetn)
      && !use_user_patterns && code_valid |-> $past(char_code) < 8'ha0)
      else $error("bad code");
   cover property (frame_start);
   cover property (use_user_patterns && char_rows == 5'h10);
   cover property (!pattern_row_visible);
endmodule
bind lcd_char_format lcd_char_format_assertions lcd_char_format_assertions_inst
(
   .hclk(hclk), .hresetn(hresetn), .char_code(char_code),
   .line_start(line_start), .frame_start(frame_start), .line_byte(line_byte),
   .frame_line(frame_line), .pattern_row(pattern_row),
   .pattern_row_visible(pattern_row_visible), .char_rows(char_rows),
   .use_user_patterns(use_user_patterns), .one_bpp_only(one_bpp_only),
   .pattern_count(pattern_count), .code_valid(code_valid)
);
`default_nettype wire

// File: test/tb_top.sv
// Bench for the character format block
`timescale 1ns/1ps
`default_nettype none
`include "lcd_char_format_regs.vh"
module tb_top;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [7:0]  char_code = 8'h9a;
   logic [15:0] cg_start_addr = 16'h1000, user_pattern_addr;
   logic [7:0]  line_byte, frame_line, gap;
   logic [4:0]  pattern_row, char_rows, fixed_height;
   logic [3:0]  cell_row, fixed_width;
   logic [8:0]  pattern_count;
   logic        line_start, frame_start, panel_alt, code_valid, display_active;
   logic        pattern_row_visible, use_user_patterns, one_bpp_only;
   wire         hreadyout;
   wire  [4:0]  ev = {hreadyout, line_start, panel_alt, ~panel_alt,
                      frame_start};
   int          mismatches = 0, checked = 0, n, i;
   logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c};
   logic [7:0]  rv [7] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
   logic [7:0]  wv [7] = '{8'h3d, 8'h8f, 8'h0f, 8'hff, 8'hff, 8'hff, 8'h00};
   logic [7:0]  pm [3] = '{8'h21, 8'h25, 8'h20};
   logic [15:0] pa [3] = '{16'h14d0, 16'h19a0, 16'h10d0};
   lcd_char_format lcd_char_format_inst
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
      .char_code(char_code), .cg_start_addr(cg_start_addr),
      .line_start(line_start), .frame_start(frame_start),
      .display_active(display_active),
      .panel_alt(panel_alt), .line_byte(line_byte), .frame_line(frame_line),
      .cell_row(cell_row), .pattern_row(pattern_row),
      .one_bpp_only(one_bpp_only),
      .pattern_row_visible(pattern_row_visible), .char_rows(char_rows),
      .use_user_patterns(use_user_patterns), .cell_width_m1(),
      .pattern_count(pattern_count), .fixed_width(fixed_width),
      .fixed_height(fixed_height),
      .code_valid(code_valid), .user_pattern_addr(user_pattern_addr)
   );
   lcd_panel_model lcd_panel_model_inst
   (
      .hclk(hclk), .panel_alt(panel_alt), .line_byte(line_byte),
      .frame_line(frame_line), .gap(gap)
   );
   always #12.5 hclk = ~hclk;
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task stop_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Bounded wait; a hang here ends the run as a failure
   task wait_on(input int s);
      n = 0;
      do
         @(posedge hclk) n++;
      while (ev[s] !== 1'b1 && n < 3000);
      if (n > 2999)
      begin
         mismatches++;
         stop_test;
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
      htrans <= `HTRANS_NONSEQ;
      haddr  <= {24'h000000, a};
      hwrite <= w;
      wait_on(4);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      wait_on(4);
      rd = hrdata;
   endtask
   task t_regs;
      for (i = 0; i < 7; i++)
      begin
         ahb(1'b0, ra[i], 8'h00);
         chk(rd, {24'h000000, rv[i]});
         ahb(1'b1, ra[i], 8'hff);
         ahb(1'b0, ra[i], 8'h00);
         chk(rd, {24'h000000, wv[i]});
      end
      chk(32'(char_rows), 32'h10);
      chk(32'(one_bpp_only), 32'h1);
      chk(32'(pattern_count), 32'h100);
      chk(32'(fixed_width), 32'h5);
      chk(32'(fixed_height), 32'h7);
      $display("t_regs done");
   endtask
   task t_pat;
      ahb(1'b1, 8'h08, 8'h00);
      for (i = 0; i < 3; i++)
      begin
         ahb(1'b1, 8'h00, pm[i]);
         repeat (3) @(posedge hclk);
         chk(32'(user_pattern_addr), 32'(pa[i]));
         chk(32'(pattern_row), 32'h0);
      end
      ahb(1'b1, 8'h00, 8'h00);
      repeat (3) @(posedge hclk);
      chk(32'(pattern_row), 32'h1f);
      chk(32'(pattern_row_visible), 32'h0);
      chk(32'(code_valid), 32'h1);
      // First code past the fixed set must be refused
      char_code <= 8'ha0;
      repeat (2) @(posedge hclk);
      chk(32'(code_valid), 32'h0);
      $display("t_pat done");
   endtask
   task t_alt;
      ahb(1'b1, 8'h0c, 8'h01);
      ahb(1'b1, 8'h10, 8'h06);
      ahb(1'b1, 8'h08, 8'h02);
      ahb(1'b1, 8'h18, 8'h17);
      ahb(1'b1, 8'h04, 8'h00);
      wait_on(3);
      wait_on(3);
      chk(n, 32'h5);
      // Two display slots out of five per line
      n = 0;
      repeat (5)
      begin
         @(posedge hclk);
         if (display_active === 1'b1)
            n++;
      end
      chk(n, 32'h2);
      wait_on(1);
      wait_on(2);
      repeat (8) @(posedge hclk);
      chk(32'(gap), 32'h10);
      wait_on(0);
      @(posedge hclk);
      chk(32'(panel_alt), 32'h0);
      wait_on(3);
      wait_on(3);
      chk(32'(cell_row), 32'h2);
      wait_on(3);
      chk(32'(cell_row), 32'h0);
      ahb(1'b1, 8'h04, 8'h80);
      wait_on(1);
      wait_on(2);
      wait_on(1);
      repeat (8) @(posedge hclk);
      chk(32'(gap), 32'h18);
      $display("t_alt done");
   endtask
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_pat;
      t_alt;
      stop_test;
   end
endmodule
`default_nettype wire
